/* inc/can_mask_pkg.sv */
// Purpose : shared constants and carriers for the receive-mask and error/status block
// Assumes : 32-bit register port, word offsets chosen locally
// Notes   : status layout follows the 16-bit error and status register
package can_mask_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] global_mask_off   = 8'h00;
  localparam logic [7:0] buf14_mask_off    = 8'h04;
  localparam logic [7:0] buf15_mask_off    = 8'h08;
  localparam logic [7:0] status_off        = 8'h0c;
  localparam logic [7:0] control_off       = 8'h10;

  // ----------------------------------------------------------------
  // mask layout
  // ----------------------------------------------------------------
  localparam int          mask_std_hi      = 31;
  localparam int          mask_std_lo      = 21;
  localparam int          mask_rtr_hi_pos  = 20;
  localparam int          mask_ide_pos     = 19;
  localparam int          mask_ext_hi      = 18;
  localparam int          mask_ext_lo      = 1;
  localparam int          mask_rtr_lo_pos  = 0;
  localparam logic [31:0] mask_reset       = 32'hfff7_fffe;
  // fixed bits: ide forced one, both rtr positions forced zero
  localparam logic [31:0] mask_force_one   = 32'h0008_0000;
  localparam logic [31:0] mask_force_zero  = 32'h0010_0001;

  // ----------------------------------------------------------------
  // status layout
  // ----------------------------------------------------------------
  localparam int          st_tx_bit_error_code_hi     = 15;
  localparam int          st_tx_bit_error_code_lo     = 14;
  localparam int          st_ack_pos       = 13;
  localparam int          st_crc_pos       = 12;
  localparam int          st_form_pos      = 11;
  localparam int          st_stuff_pos     = 10;
  localparam int          st_tx_counter_warning_pos    = 9;
  localparam int          st_rx_counter_warning_pos    = 8;
  localparam int          st_idle_pos      = 7;
  localparam int          st_txrx_pos      = 6;
  localparam int          st_fcs_hi        = 5;
  localparam int          st_fcs_lo        = 4;
  localparam int          st_boff_pos      = 2;
  localparam int          st_err_pos       = 1;
  localparam int          st_wake_pos      = 0;
  localparam logic [7:0]  warn_level       = 8'd96;

  // control register bits
  localparam int          ctl_boff_en_pos  = 0;
  localparam int          ctl_err_en_pos   = 1;
  localparam int          ctl_wake_en_pos  = 2;

  localparam logic [1:0]  tx_bit_error_code_none      = 2'h0;
  localparam logic [1:0]  tx_bit_error_code_dom_rec   = 2'h1;
  localparam logic [1:0]  tx_bit_error_code_rec_dom   = 2'h2;
  localparam logic [1:0]  fcs_active       = 2'h0;
  localparam logic [1:0]  fcs_passive      = 2'h1;
  localparam logic [1:0]  fcs_busoff       = 2'h2;
  localparam logic [1:0]  fcs_reset        = 2'h0;
  localparam logic [31:0] bad_addr_data    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [28:0] ident;
    logic        ide;
    logic        rtr;
  } frame_id_type;

  typedef struct packed {
    logic bit_dom_rec;   // dominant sent, recessive seen
    logic bit_rec_dom;   // recessive sent, dominant seen
    logic in_arb_or_ack; // arbitration field or ack slot
    logic passive_err_tx;
    logic ack_err;
    logic crc_err;
    logic form_err;
    logic stuff_err;
  } err_event_type;

endpackage : can_mask_pkg

/* hw/can_rx_mask_error_status.sv */
// Purpose : acceptance masks for receive buffers and the error and status register
// Assumes : one clock, protocol engine supplies events on the same clock
// Notes   : single-cycle register port, read data one cycle after the read strobe
//
// Notes on behaviour
// - buffers 0-13 use the global mask; 14 and 15 use their own.
// - masks are 32 bits; bits 31-21 mask identifier bits 28-18.
// - mask zero ignores the bit; mask one requires equality.
// - mask bits 18-1 cover identifier 17-0, extended frames only.
// - ide always compared; its mask bit reads one whatever is written.
// - rtr never compared; mask bits 20 and 0 read zero after any write; bit 20 reads one from reset.
// - remote request frames never match any buffer.
// - error bits 15-10 collect events since last read; read clears them.
// - status read-only except three interrupt flags, writable to zero.
// - bit error code 01 dominant-read-recessive, 10 recessive-read-dominant.
// - bit error code frozen in arbitration, ack slot, passive error frame.
// - bit 13 set on ack error, held until read.
// - bit 12 set on crc error, held until read.
// - bit 11 set on format error, held until read.
// - bit 10 set on stuffing error, held until read.
// - bit 9 shows transmit error counter at least 96.
// - bit 8 shows receive error counter at least 96.
// - bit 7 shows bus idle.
// - bit 6 shows transmitting when bus is busy.
// - bits 5-4 show fault confinement state.
// - soft reset clears status; bus off shows again right after.
// - bit 2 set on entering bus off; request if enabled.
// - bit 1 set with any error bit; request if enabled.
// - bit 0 set on wake edge in stop mode; request if enabled.
`timescale 1ns/1ns
`default_nettype none

module can_rx_mask_error_status (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        module_soft_reset,
  // register port
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  // frame to be filtered against all sixteen buffers
  input  wire logic                        frame_valid,
  input  wire can_mask_pkg::frame_id_type  frame_id,
  input  wire can_mask_pkg::frame_id_type  buffer_id [16],
  output logic      [15:0]                 buffer_match,
  // protocol engine state and events
  input  wire can_mask_pkg::err_event_type err_event,
  input  wire logic [7:0]                  tx_err_count,
  input  wire logic [7:0]                  rx_err_count,
  input  wire logic                        bus_idle,
  input  wire logic                        node_transmitting,
  input  wire logic [1:0]                  confinement_in,
  input  wire logic                        stop_mode,
  input  wire logic                        can_rx_pin,
  // interrupt requests
  output logic                             busoff_irq,
  output logic                             error_irq,
  output logic                             wakeup_irq
);

  // ----------------------------------------------------------------
  // register strobes
  // ----------------------------------------------------------------
  logic        wr_gm;
  logic        wr_m14;
  logic        wr_m15;
  logic        wr_st;
  logic        wr_ctl;
  logic        rd_st;
  logic        any_rst;
  assign wr_gm   = reg_wr && reg_addr == can_mask_pkg::global_mask_off;
  assign wr_m14  = reg_wr && reg_addr == can_mask_pkg::buf14_mask_off;
  assign wr_m15  = reg_wr && reg_addr == can_mask_pkg::buf15_mask_off;
  assign wr_st   = reg_wr && reg_addr == can_mask_pkg::status_off;
  assign wr_ctl  = reg_wr && reg_addr == can_mask_pkg::control_off;
  assign rd_st   = reg_rd && reg_addr == can_mask_pkg::status_off;
  assign any_rst = sys_rst || module_soft_reset;

  // ----------------------------------------------------------------
  // mask registers
  // ----------------------------------------------------------------
  logic [31:0] global_receive_mask_q;
  logic [31:0] buffer14_receive_mask_q;
  logic [31:0] buffer15_receive_mask_q;
  logic [31:0] mask_wr_d;
  logic [2:0]  control_register_zero_q;

  // fixed bits are forced on the way in so a read shows them too
  assign mask_wr_d = (reg_wdata | can_mask_pkg::mask_force_one)
                     & ~can_mask_pkg::mask_force_zero;

  // masks survive soft reset; only the system reset restores them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      global_receive_mask_q   <= can_mask_pkg::mask_reset;
      buffer14_receive_mask_q <= can_mask_pkg::mask_reset;
      buffer15_receive_mask_q <= can_mask_pkg::mask_reset;
    end else begin
      if (wr_gm)  global_receive_mask_q   <= mask_wr_d;
      if (wr_m14) buffer14_receive_mask_q <= mask_wr_d;
      if (wr_m15) buffer15_receive_mask_q <= mask_wr_d;
    end
  end

  // interrupt enables
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      control_register_zero_q <= 3'h0;
    end else if (wr_ctl) begin
      control_register_zero_q <= reg_wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // acceptance filter
  // ----------------------------------------------------------------
  logic [15:0] match_d;

  always_comb begin
    logic [31:0] m;
    logic [28:0] care;
    logic [28:0] diff;
    m    = 32'h0;
    care = 29'h0;
    diff = 29'h0;
    for (int b = 0; b < 16; b++) begin
      unique case (b)
        14:      m = buffer14_receive_mask_q;
        15:      m = buffer15_receive_mask_q;
        default: m = global_receive_mask_q;
      endcase
      care[28:18] = m[can_mask_pkg::mask_std_hi:can_mask_pkg::mask_std_lo];
      // extended bits only matter for extended frames
      care[17:0]  = frame_id.ide ? m[can_mask_pkg::mask_ext_hi:can_mask_pkg::mask_ext_lo]
                                 : 18'h0;
      diff        = frame_id.ident ^ buffer_id[b].ident;
      match_d[b]  = frame_valid && !frame_id.rtr
                    && frame_id.ide == buffer_id[b].ide
                    && (diff & care) == 29'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) buffer_match <= 16'h0;
    else         buffer_match <= match_d;
  end

  // ----------------------------------------------------------------
  // wake edge detection on the bus pin
  // ----------------------------------------------------------------
  logic       rx_meta_q;
  logic       rx_sync_q;
  logic       rx_prev_q;
  logic       wake_edge;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= can_rx_pin;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end
  assign wake_edge = stop_mode && rx_prev_q && !rx_sync_q;

  // ----------------------------------------------------------------
  // error and status register
  // ----------------------------------------------------------------
  logic [1:0] tx_bit_error_code_q;
  logic       ack_error_flag_q;
  logic       checksum_error_flag_q;
  logic       format_error_flag_q;
  logic       stuffing_error_flag_q;
  logic       busoff_irq_flag_q;
  logic       error_irq_flag_q;
  logic       wakeup_irq_flag_q;
  logic       bit_upd;
  logic       any_err;
  logic       busoff_prev_q;
  logic       busoff_entry;
  logic [15:0] status_view;

  // the code is frozen where bit errors are legal protocol behaviour
  assign bit_upd = !err_event.in_arb_or_ack && !err_event.passive_err_tx
                   && (err_event.bit_dom_rec || err_event.bit_rec_dom);
  assign any_err = bit_upd || err_event.ack_err || err_event.crc_err
                   || err_event.form_err || err_event.stuff_err;
  assign busoff_entry = confinement_in[1] && !busoff_prev_q;

  // sticky error bits: a new event in the read cycle wins over the clear
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      tx_bit_error_code_q   <= can_mask_pkg::tx_bit_error_code_none;
      ack_error_flag_q      <= 1'b0;
      checksum_error_flag_q <= 1'b0;
      format_error_flag_q   <= 1'b0;
      stuffing_error_flag_q <= 1'b0;
    end else begin
      if (bit_upd)
        tx_bit_error_code_q <= err_event.bit_dom_rec ? can_mask_pkg::tx_bit_error_code_dom_rec
                                                     : can_mask_pkg::tx_bit_error_code_rec_dom;
      else if (rd_st)
        tx_bit_error_code_q <= can_mask_pkg::tx_bit_error_code_none;
      ack_error_flag_q      <= err_event.ack_err   || (ack_error_flag_q && !rd_st);
      checksum_error_flag_q <= err_event.crc_err   || (checksum_error_flag_q && !rd_st);
      format_error_flag_q   <= err_event.form_err  || (format_error_flag_q && !rd_st);
      stuffing_error_flag_q <= err_event.stuff_err || (stuffing_error_flag_q && !rd_st);
    end
  end

  // interrupt flags: written zero clears only when no new event arrives
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      busoff_irq_flag_q <= 1'b0;
      error_irq_flag_q  <= 1'b0;
      wakeup_irq_flag_q <= 1'b0;
      busoff_prev_q     <= 1'b0;
    end else begin
      busoff_prev_q     <= confinement_in[1];
      busoff_irq_flag_q <= busoff_entry
                           || (busoff_irq_flag_q
                               && !(wr_st && !reg_wdata[can_mask_pkg::st_boff_pos]));
      error_irq_flag_q  <= any_err
                           || (error_irq_flag_q
                               && !(wr_st && !reg_wdata[can_mask_pkg::st_err_pos]));
      wakeup_irq_flag_q <= wake_edge
                           || (wakeup_irq_flag_q
                               && !(wr_st && !reg_wdata[can_mask_pkg::st_wake_pos]));
    end
  end

  // live status fields; confinement follows its source so bus off reappears
  always_comb begin
    status_view = 16'h0;
    status_view[can_mask_pkg::st_tx_bit_error_code_hi:can_mask_pkg::st_tx_bit_error_code_lo] = tx_bit_error_code_q;
    status_view[can_mask_pkg::st_ack_pos]    = ack_error_flag_q;
    status_view[can_mask_pkg::st_crc_pos]    = checksum_error_flag_q;
    status_view[can_mask_pkg::st_form_pos]   = format_error_flag_q;
    status_view[can_mask_pkg::st_stuff_pos]  = stuffing_error_flag_q;
    status_view[can_mask_pkg::st_tx_counter_warning_pos] = tx_err_count >= can_mask_pkg::warn_level;
    status_view[can_mask_pkg::st_rx_counter_warning_pos] = rx_err_count >= can_mask_pkg::warn_level;
    status_view[can_mask_pkg::st_idle_pos]   = bus_idle;
    status_view[can_mask_pkg::st_txrx_pos]   = node_transmitting;
    status_view[can_mask_pkg::st_fcs_hi:can_mask_pkg::st_fcs_lo] =
      module_soft_reset ? can_mask_pkg::fcs_reset : confinement_in;
    status_view[can_mask_pkg::st_boff_pos]   = busoff_irq_flag_q;
    status_view[can_mask_pkg::st_err_pos]    = error_irq_flag_q;
    status_view[can_mask_pkg::st_wake_pos]   = wakeup_irq_flag_q;
  end

  // interrupt outputs registered to keep them glitch free
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      busoff_irq <= 1'b0;
      error_irq  <= 1'b0;
      wakeup_irq <= 1'b0;
    end else begin
      busoff_irq <= busoff_irq_flag_q && control_register_zero_q[can_mask_pkg::ctl_boff_en_pos];
      error_irq  <= error_irq_flag_q  && control_register_zero_q[can_mask_pkg::ctl_err_en_pos];
      wakeup_irq <= wakeup_irq_flag_q && control_register_zero_q[can_mask_pkg::ctl_wake_en_pos];
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        can_mask_pkg::global_mask_off: reg_rdata <= global_receive_mask_q;
        can_mask_pkg::buf14_mask_off:  reg_rdata <= buffer14_receive_mask_q;
        can_mask_pkg::buf15_mask_off:  reg_rdata <= buffer15_receive_mask_q;
        can_mask_pkg::status_off:      reg_rdata <= {16'h0, status_view};
        can_mask_pkg::control_off:     reg_rdata <= {29'h0, control_register_zero_q};
        default:                       reg_rdata <= can_mask_pkg::bad_addr_data;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence read_status_s;
    rd_st && !sys_rst && !module_soft_reset;
  endsequence

  mask_fixed_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_gm |=> global_receive_mask_q[19] && !global_receive_mask_q[20]
              && !global_receive_mask_q[0])
    else $error("fixed mask bits wrong");

  remote_never_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    frame_valid && frame_id.rtr |=> buffer_match == 16'h0)
    else $error("remote frame matched");

  read_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    read_status_s ##0 !err_event.ack_err |=> !ack_error_flag_q)
    else $error("ack flag not cleared by read");

  crc_sticky_a: assert property (@(posedge ref_clk) disable iff (any_rst)
    err_event.crc_err |=> checksum_error_flag_q)
    else $error("crc flag not set");

  tx_bit_error_code_frozen_a: assert property (@(posedge ref_clk) disable iff (any_rst)
    err_event.in_arb_or_ack && !rd_st |=> $stable(tx_bit_error_code_q))
    else $error("bit error code changed in arbitration");

  warn_level_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_rd && reg_addr == can_mask_pkg::status_off && tx_err_count >= 8'd96
    |=> reg_rdata[9])
    else $error("tx warning missing");

  flag_clear_a: assert property (@(posedge ref_clk) disable iff (any_rst)
    wr_st && !reg_wdata[1] && !any_err ##1 !any_err |=> !error_irq)
    else $error("error flag not cleared");

  busoff_irq_a: assert property (@(posedge ref_clk) disable iff (any_rst)
    busoff_entry && control_register_zero_q[0] && !wr_ctl |=> ##1 busoff_irq)
    else $error("bus off interrupt missing");

  ack_flag_a: assert property (
    @(posedge ref_clk)
    disable iff (any_rst)
    err_event.ack_err
    |=> ack_error_flag_q
  ) else $error("ack flag");

  form_flag_a: assert property (
    @(posedge ref_clk)
    disable iff (any_rst)
    err_event.form_err
    |=> format_error_flag_q
  ) else $error("form flag");

  stuff_flag_a: assert property (
    @(posedge ref_clk)
    disable iff (any_rst)
    err_event.stuff_err
    |=> stuffing_error_flag_q
  ) else $error("stuff flag");

  fcs_soft_a: assert property (
    @(posedge ref_clk)
    disable iff (sys_rst)
    rd_st && module_soft_reset
    |=> reg_rdata[5:4] == 2'h0
  ) else $error("fcs in reset");

  rx_warn_a: assert property (
    @(posedge ref_clk)
    disable iff (sys_rst)
    rd_st && rx_err_count >= can_mask_pkg::warn_level
    |=> reg_rdata[8]
  ) else $error("rx warning");

endmodule : can_rx_mask_error_status

`default_nettype wire

/* bench/can_bus_node_model.sv */
// Purpose : behavioural far side: protocol engine state, error events and bus pin
// Assumes : single clock shared with the block under test
// Notes   : the bench steers it through its tasks; outputs change just after an edge
`timescale 1ns/1ns
`default_nettype none

module can_bus_node_model (
  // clock
  input  wire logic                        ref_clk,
  // engine side
  output can_mask_pkg::err_event_type      err_event,
  output logic      [7:0]                  tx_err_count,
  output logic      [7:0]                  rx_err_count,
  output logic                             bus_idle,
  output logic                             node_transmitting,
  output logic      [1:0]                  confinement_in,
  output logic                             can_rx_pin
);
  // idle bus is recessive, so the pin rests high
  initial begin
    err_event         = '0;
    tx_err_count      = 8'h00;
    rx_err_count      = 8'h00;
    bus_idle          = 1'b1;
    node_transmitting = 1'b0;
    confinement_in    = 2'h0;
    can_rx_pin        = 1'b1;
  end

  // events are one-cycle pulses, never left standing
  task automatic pulse(input can_mask_pkg::err_event_type ev);
    @(posedge ref_clk) err_event <= ev;
    @(posedge ref_clk) err_event <= '0;
  endtask : pulse

  task automatic set_state(input logic [7:0] tx, input logic [7:0] rx, input logic idle,
                           input logic txing, input logic [1:0] fault_confinement_state);
    @(posedge ref_clk);
    tx_err_count      <= tx;
    rx_err_count      <= rx;
    bus_idle          <= idle;
    node_transmitting <= txing;
    confinement_in    <= fault_confinement_state;
  endtask : set_state

  task automatic drive_pin(input logic level);
    @(posedge ref_clk) can_rx_pin <= level;
  endtask : drive_pin
endmodule : can_bus_node_model

`default_nettype wire

/* bench/can_rx_mask_error_status_bench.sv */
// Purpose : self-checking bench for the receive masks and the error/status register
// Assumes : partner model drives the protocol-engine inputs
// Notes   : status compared with the idle bit as base while the bus rests
`timescale 1ns/1ns
`default_nettype none

module can_rx_mask_error_status_bench;
  logic ref_clk, sys_rst, soft_rst, reg_wr, reg_rd, frame_valid, stop_mode, bus_idle;
  logic node_tx, can_rx_pin, busoff_irq, error_irq, wakeup_irq;
  logic [7:0] reg_addr, tx_cnt, rx_cnt;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [15:0] buffer_match;
  logic [1:0] conf;
  can_mask_pkg::frame_id_type  frame_id;
  can_mask_pkg::frame_id_type  buffer_id [16];
  can_mask_pkg::err_event_type err_event;
  int bad_count, check_count;
  localparam logic [31:0] base = 32'h0000_0080; // idle bus, no errors

  can_rx_mask_error_status u_can_rx_mask_error_status (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .module_soft_reset(soft_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_valid(frame_valid), .frame_id(frame_id),
    .buffer_id(buffer_id), .buffer_match(buffer_match), .err_event(err_event),
    .tx_err_count(tx_cnt), .rx_err_count(rx_cnt), .bus_idle(bus_idle),
    .node_transmitting(node_tx), .confinement_in(conf), .stop_mode(stop_mode),
    .can_rx_pin(can_rx_pin), .busoff_irq(busoff_irq), .error_irq(error_irq),
    .wakeup_irq(wakeup_irq));
  can_bus_node_model u_can_bus_node_model (.ref_clk(ref_clk), .err_event(err_event),
    .tx_err_count(tx_cnt), .rx_err_count(rx_cnt), .bus_idle(bus_idle),
    .node_transmitting(node_tx), .confinement_in(conf), .can_rx_pin(can_rx_pin));

  // ----------------------------------------------------------------
  // reporting and bus cycles
  // ----------------------------------------------------------------
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic read_check(input string name, input logic [7:0] a, input logic [31:0] exp);
    reg_read(a, rd);
    check_val(name, exp, rd);
  endtask : read_check

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic mask_fixed_bits;
    logic [7:0] offs [3];
    offs = '{can_mask_pkg::global_mask_off, can_mask_pkg::buf14_mask_off,
             can_mask_pkg::buf15_mask_off};
    foreach (offs[i]) begin
      reg_write(offs[i], 32'hffff_ffff);
      read_check("mask ones", offs[i], 32'hffef_fffe);
      reg_write(offs[i], 32'h0000_0000);
      read_check("mask zeros", offs[i], 32'h0008_0000);
    end
    read_check("unmapped", 8'h40, 32'h0000_0000);
  endtask : mask_fixed_bits

  // global compares all, buffer 14 only ide, buffer 15 standard bits only
  task automatic filter_frames;
    logic [31:0] m [3];
    can_mask_pkg::frame_id_type fr [5];
    logic [15:0] exp;
    m = '{32'hffef_fffe, 32'h0008_0000, 32'hffe8_0000};
    fr = '{'{29'h3, 1'b1, 1'b0}, '{29'h2, 1'b0, 1'b0}, '{29'h3, 1'b1, 1'b1},
           '{29'h4_0002, 1'b0, 1'b0}, '{29'h5, 1'b1, 1'b0}};
    reg_write(can_mask_pkg::global_mask_off, m[0]);
    reg_write(can_mask_pkg::buf14_mask_off, 32'h0000_0000);
    reg_write(can_mask_pkg::buf15_mask_off, 32'hffe0_0001);
    for (int b = 0; b < 16; b++) buffer_id[b] <= '{29'(b), b[0], 1'b0};
    foreach (fr[f]) begin
      for (int b = 0; b < 16; b++) begin
        exp[b] = !fr[f].rtr && fr[f].ide == b[0]
          && (((fr[f].ident ^ 29'(b)) >> 18) & 29'(m[b < 14 ? 0 : b - 13] >> 21)) == 0
          && (!fr[f].ide || ((fr[f].ident ^ 29'(b)) & 29'(m[b < 14 ? 0 : b - 13] >> 1)
              & 29'h3_ffff) == 0);
      end
      @(posedge ref_clk) begin frame_valid <= 1'b1; frame_id <= fr[f]; end
      @(posedge ref_clk) frame_valid <= 1'b0;
      #1 check_val("match", {16'h0, exp}, {16'h0, buffer_match});
    end
  endtask : filter_frames

  task automatic error_flags;
    for (int k = 0; k < 4; k++) begin
      u_can_bus_node_model.pulse(8'(8'h08 >> k));
      read_check("err set", can_mask_pkg::status_off,
                 base | 32'h2 | (32'h2000 >> k));
      read_check("err read clear", can_mask_pkg::status_off, base | 32'h2);
      reg_write(can_mask_pkg::status_off, 32'h0000_ffff);
      read_check("write ones", can_mask_pkg::status_off, base | 32'h2);
      reg_write(can_mask_pkg::status_off, 32'h0000_0000);
      read_check("flag cleared", can_mask_pkg::status_off, base);
    end
  endtask : error_flags

  task automatic bit_errors;
    logic [7:0]  ev [4];
    logic [31:0] code [4];
    ev = '{8'h80, 8'h40, 8'ha0, 8'h50};
    code = '{32'h4000, 32'h8000, 32'h0, 32'h0};
    foreach (ev[i]) begin
      u_can_bus_node_model.pulse(ev[i]);
      reg_read(can_mask_pkg::status_off, rd);
      check_val("bit error code", code[i], rd & 32'hc000);
      reg_write(can_mask_pkg::status_off, 32'h0000_0000);
    end
  endtask : bit_errors

  task automatic status_levels;
    u_can_bus_node_model.set_state(8'd95, 8'd96, 1'b0, 1'b1, 2'h1);
    read_check("levels a", can_mask_pkg::status_off, 32'h0150);
    u_can_bus_node_model.set_state(8'd96, 8'd95, 1'b1, 1'b0, 2'h0);
    read_check("levels b", can_mask_pkg::status_off, 32'h0280);
  endtask : status_levels

  task automatic irq_paths;
    reg_write(can_mask_pkg::control_off, 32'h7);
    u_can_bus_node_model.pulse(8'h04);
    @(posedge ref_clk) #1 check_val("error irq", 1, error_irq);
    reg_read(can_mask_pkg::status_off, rd);
    reg_write(can_mask_pkg::status_off, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    #1 check_val("error irq off", 0, error_irq);
    u_can_bus_node_model.set_state(8'd0, 8'd0, 1'b1, 1'b0, 2'h2);
    repeat (3) @(posedge ref_clk);
    #1 check_val("busoff irq", 1, busoff_irq);
    read_check("busoff status", can_mask_pkg::status_off, base | 32'h24);
    @(posedge ref_clk) soft_rst <= 1'b1;
    reg_read(can_mask_pkg::status_off, rd);
    check_val("fcs in reset", 0, rd & 32'h30);
    @(posedge ref_clk) soft_rst <= 1'b0;
    reg_read(can_mask_pkg::status_off, rd);
    check_val("fcs after", 32'h20, rd & 32'h30);
    u_can_bus_node_model.set_state(8'd0, 8'd0, 1'b1, 1'b0, 2'h0);
    reg_write(can_mask_pkg::control_off, 32'h4);
    reg_write(can_mask_pkg::status_off, 32'h0000_0000);
    @(posedge ref_clk) stop_mode <= 1'b1;
    u_can_bus_node_model.drive_pin(1'b0);
    for (int n = 0; n < 10 && wakeup_irq !== 1'b1; n++) @(posedge ref_clk);
    #1 check_val("wake irq", 1, wakeup_irq);
    read_check("wake flag", can_mask_pkg::status_off, base | 32'h1);
  endtask : irq_paths

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    {sys_rst, soft_rst, reg_wr, reg_rd, frame_valid, stop_mode} = 6'b100000;
    {reg_addr, reg_wdata, frame_id} = '0;
    for (int b = 0; b < 16; b++) buffer_id[b] = '0;
    bad_count = 0;
    check_count = 0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    mask_fixed_bits();
    filter_frames();
    error_flags();
    bit_errors();
    status_levels();
    irq_paths();
    complete_run();
  end
endmodule : can_rx_mask_error_status_bench

`default_nettype wire
